// >>> hdl/bfd_pkg.sv
// Shared constants for the branch field decoder
package bfd_pkg;

    // ------------------------------------------------------------
    // Field positions, counted with bit 0 as the instruction MSB
    // ------------------------------------------------------------
    localparam int INSN_W          = 32;
    localparam int ADDR_W          = 32;
    localparam int POS_ABS_FLAG    = 30;
    localparam int POS_RECORD      = 31;
    localparam int SHORT_OFS_FIRST = 16;
    localparam int SHORT_OFS_LAST  = 29;
    localparam int LONG_OFS_FIRST  = 6;
    localparam int LONG_OFS_LAST   = 29;
    localparam int COND_SEL_FIRST  = 11;
    localparam int OPTIONS_FIRST   = 6;
    localparam int FLAG_SRC_FIRST  = 11;
    localparam int BASE_SEL_FIRST  = 11;
    localparam int FIELD_SEL_FIRST = 6;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int SHORT_OFS_W   = 14;
    localparam int LONG_OFS_W    = 24;
    localparam int BIT_SEL_W     = 5;
    localparam int FIELD_SEL_W   = 3;
    localparam int OFS_PAD_W     = 2;
    localparam int FLAG_FIELDS   = 8;
    localparam int FLAG_BITS     = 32;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0]      RST_ADDR     = 32'h0000_0000;
    localparam logic [BIT_SEL_W-1:0]   RST_BIT_SEL  = 5'h00;
    localparam logic [FIELD_SEL_W-1:0] RST_FIELD    = 3'h0;
    localparam logic [BIT_SEL_W-1:0]   BASE_ZERO_ID = 5'h00;
    localparam logic [OFS_PAD_W-1:0]   OFS_PAD      = 2'h0;

endpackage

// >>> hdl/bfd_target_calc.sv
// Branch displacement extraction and target address arithmetic
`timescale 1ns/1ps
`default_nettype none

module bfd_target_calc (
    input  wire logic [bfd_pkg::INSN_W-1:0] insn,
    input  wire logic [bfd_pkg::ADDR_W-1:0] insn_addr,
    input  wire logic                       long_form,
    output logic      [bfd_pkg::ADDR_W-1:0] target
);

    // ------------------------------------------------------------
    // Field extraction, MSB-first numbering
    // ------------------------------------------------------------
    // [RULE11] MSB is bit 0
    function automatic int vbit(input int doc_bit);
        return bfd_pkg::INSN_W - 1 - doc_bit;
    endfunction

    logic [bfd_pkg::SHORT_OFS_W-1:0] short_ofs;
    logic [bfd_pkg::LONG_OFS_W-1:0]  long_ofs;
    logic [bfd_pkg::ADDR_W-1:0]      disp;
    logic                            abs_flag;

    // [RULE3] short offset bits 16:29
    assign short_ofs = insn[vbit(bfd_pkg::SHORT_OFS_FIRST) -: bfd_pkg::SHORT_OFS_W];
    // [RULE10] long offset bits 6:29
    assign long_ofs  = insn[vbit(bfd_pkg::LONG_OFS_FIRST) -: bfd_pkg::LONG_OFS_W];
    assign abs_flag  = insn[vbit(bfd_pkg::POS_ABS_FLAG)];

    always_comb begin
        // [RULE3] append two zeros, sign extend
        disp = {{(bfd_pkg::ADDR_W - bfd_pkg::SHORT_OFS_W - bfd_pkg::OFS_PAD_W){short_ofs[bfd_pkg::SHORT_OFS_W-1]}},
                short_ofs, bfd_pkg::OFS_PAD};
        if (long_form) begin
            // [RULE10] append two zeros, sign extend
            disp = {{(bfd_pkg::ADDR_W - bfd_pkg::LONG_OFS_W - bfd_pkg::OFS_PAD_W){long_ofs[bfd_pkg::LONG_OFS_W-1]}},
                    long_ofs, bfd_pkg::OFS_PAD};
        end
        if (abs_flag) begin
            // [RULE2] absolute target
            target = disp;
        end else begin
            // [RULE1] relative target, wraps modulo 2^32
            target = bfd_pkg::ADDR_W'(insn_addr + disp);
        end
    end

endmodule

`default_nettype wire

// >>> hdl/bfd_branch_field_decoder.sv
// Branch, flag and base-operand field decoder for a 32-bit core
//
// What this block does
// [RULE1] With the absolute flag clear the target is the instruction address plus the sign-extended offset.
// [RULE2] With the absolute flag set the target is the sign-extended offset alone.
// [RULE3] Conditional branches use the 14-bit offset at bits 16:29, padded with two zeros and sign-extended.
// [RULE4] Bits 11:15 of a conditional branch pick the single flag bit that is tested.
// [RULE5] Bits 6:10 of a conditional branch are the branch control options.
// [RULE6] Bits 11:15 of a flag-logic instruction pick its first source flag bit.
// [RULE7] A base-or-zero operand is the selected register, or zero when the selector is 0.
// [RULE8] A record-form instruction writes status into a flag field; the plain form leaves flags alone.
// [RULE9] Flag bit selectors cover 0 to 31 and flag field selectors cover fields 0 to 7.
// [RULE10] Unconditional branches use the 24-bit offset at bits 6:29, padded with two zeros and sign-extended.
// [RULE11] Instruction bits are numbered with the MSB as bit 0 for every field.
`timescale 1ns/1ps
`default_nettype none

module bfd_branch_field_decoder #(
    parameter logic [2:0] RECORD_FIELD = 3'h0
) (
    input  wire logic        REF_CLK,
    input  wire logic        SRST,
    input  wire logic        INSN_VALID,
    input  wire logic [31:0] INSN,
    input  wire logic [31:0] CURRENT_INSN_ADDR,
    input  wire logic        LONG_FORM,
    input  wire logic        RECORD_CAPABLE,
    input  wire logic [31:0] BASE_REG_DATA,
    output logic             DEC_VALID,
    output logic [31:0]      BRANCH_TARGET_ADDR,
    output logic             ABSOLUTE_ADDRESS_FLAG,
    output logic [4:0]       BRANCH_CONDITION_SELECTOR,
    output logic [4:0]       BRANCH_CONTROL_OPTIONS,
    output logic [4:0]       FLAG_LOGIC_SOURCE_ONE,
    output logic [4:0]       BASE_OPERAND_SELECT,
    output logic [31:0]      BASE_OPERAND,
    output logic             FLAG_UPDATE_EN,
    output logic [2:0]       FLAG_FIELD_SEL,
    output logic [2:0]       COMPARE_FIELD_SEL
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic                                valid;
        logic [bfd_pkg::ADDR_W-1:0]          target;
        logic                                abs_flag;
        logic [bfd_pkg::BIT_SEL_W-1:0]       cond_sel;
        logic [bfd_pkg::BIT_SEL_W-1:0]       options;
        logic [bfd_pkg::BIT_SEL_W-1:0]       src_one;
        logic [bfd_pkg::BIT_SEL_W-1:0]       base_sel;
        logic [bfd_pkg::ADDR_W-1:0]          base_val;
        logic                                flag_upd;
        logic [bfd_pkg::FIELD_SEL_W-1:0]     field_sel;
        logic [bfd_pkg::FIELD_SEL_W-1:0]     cmp_field;
    } bfd_state_t;

    bfd_state_t state_reg;
    bfd_state_t state_next;

    logic [bfd_pkg::ADDR_W-1:0] target_calc;

    // [RULE11] MSB is bit 0
    function automatic int vbit(input int doc_bit);
        return bfd_pkg::INSN_W - 1 - doc_bit;
    endfunction

    // ------------------------------------------------------------
    // Target arithmetic
    // ------------------------------------------------------------
    bfd_target_calc u_target (
        .insn      (INSN),
        .insn_addr (CURRENT_INSN_ADDR),
        .long_form (LONG_FORM),
        .target    (target_calc)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_next       = state_reg;
        state_next.valid = INSN_VALID;
        // Fields other than valid, flag_upd and field_sel hold their last value between instructions so the
        // downstream units see no glitch while idle.
        if (INSN_VALID) begin
            // [RULE1] [RULE2] target capture
            state_next.target   = target_calc;
            state_next.abs_flag = INSN[vbit(bfd_pkg::POS_ABS_FLAG)];
            // [RULE4] tested flag bit
            state_next.cond_sel = INSN[vbit(bfd_pkg::COND_SEL_FIRST) -: bfd_pkg::BIT_SEL_W];
            // [RULE5] branch options
            state_next.options  = INSN[vbit(bfd_pkg::OPTIONS_FIRST) -: bfd_pkg::BIT_SEL_W];
            // [RULE6] flag-logic source
            state_next.src_one  = INSN[vbit(bfd_pkg::FLAG_SRC_FIRST) -: bfd_pkg::BIT_SEL_W];
            state_next.base_sel = INSN[vbit(bfd_pkg::BASE_SEL_FIRST) -: bfd_pkg::BIT_SEL_W];
            // [RULE7] selector 0 reads as zero
            if (INSN[vbit(bfd_pkg::BASE_SEL_FIRST) -: bfd_pkg::BIT_SEL_W] == bfd_pkg::BASE_ZERO_ID) begin
                state_next.base_val = bfd_pkg::RST_ADDR;
            end else begin
                state_next.base_val = BASE_REG_DATA;
            end
            // [RULE9] three-bit field selector, fields 0 to 7
            state_next.cmp_field = INSN[vbit(bfd_pkg::FIELD_SEL_FIRST) -: bfd_pkg::FIELD_SEL_W];
        end
        // [RULE8] record form updates a flag field
        state_next.flag_upd  = INSN_VALID && RECORD_CAPABLE && INSN[vbit(bfd_pkg::POS_RECORD)];
        state_next.field_sel = RECORD_FIELD;
        if (SRST) begin
            state_next.valid     = 1'b0;
            state_next.target    = bfd_pkg::RST_ADDR;
            state_next.abs_flag  = 1'b0;
            state_next.cond_sel  = bfd_pkg::RST_BIT_SEL;
            state_next.options   = bfd_pkg::RST_BIT_SEL;
            state_next.src_one   = bfd_pkg::RST_BIT_SEL;
            state_next.base_sel  = bfd_pkg::RST_BIT_SEL;
            state_next.base_val  = bfd_pkg::RST_ADDR;
            state_next.flag_upd  = 1'b0;
            state_next.field_sel = bfd_pkg::RST_FIELD;
            state_next.cmp_field = bfd_pkg::RST_FIELD;
        end
    end

    always_ff @(posedge REF_CLK) begin
        state_reg <= state_next;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign DEC_VALID                 = state_reg.valid;
    assign BRANCH_TARGET_ADDR        = state_reg.target;
    assign ABSOLUTE_ADDRESS_FLAG     = state_reg.abs_flag;
    assign BRANCH_CONDITION_SELECTOR = state_reg.cond_sel;
    assign BRANCH_CONTROL_OPTIONS    = state_reg.options;
    assign FLAG_LOGIC_SOURCE_ONE     = state_reg.src_one;
    assign BASE_OPERAND_SELECT       = state_reg.base_sel;
    assign BASE_OPERAND              = state_reg.base_val;
    assign FLAG_UPDATE_EN            = state_reg.flag_upd;
    assign FLAG_FIELD_SEL            = state_reg.field_sel;
    assign COMPARE_FIELD_SEL         = state_reg.cmp_field;

endmodule

`default_nettype wire

// >>> tb/bfd_gpr_model.sv
// Register file stand-in answering the base operand read
`timescale 1ns/1ps
`default_nettype none
module bfd_gpr_model (
    input  wire logic [4:0]  sel,
    output logic      [31:0] data
);
    // Selector is folded in so a wrong register read shows
    assign data = 32'hA5A5_0000 | {27'h000_0000, sel};
endmodule
`default_nettype wire

// >>> tb/bfd_branch_field_decoder_chk.sv
// Port-level assertions for the branch field decoder
`timescale 1ns/1ps
`default_nettype none
module bfd_branch_field_decoder_chk (
    input wire logic        REF_CLK,
    input wire logic        SRST,
    input wire logic        INSN_VALID,
    input wire logic [31:0] INSN,
    input wire logic [31:0] CURRENT_INSN_ADDR,
    input wire logic        LONG_FORM,
    input wire logic        RECORD_CAPABLE,
    input wire logic        DEC_VALID,
    input wire logic [31:0] BRANCH_TARGET_ADDR,
    input wire logic        ABSOLUTE_ADDRESS_FLAG,
    input wire logic [4:0]  BASE_OPERAND_SELECT,
    input wire logic [4:0]  BRANCH_CONDITION_SELECTOR,
    input wire logic [4:0]  BRANCH_CONTROL_OPTIONS,
    input wire logic [4:0]  FLAG_LOGIC_SOURCE_ONE,
    input wire logic [31:0] BASE_OPERAND,
    input wire logic [31:0] BASE_REG_DATA,
    input wire logic        FLAG_UPDATE_EN,
    input wire logic [2:0]  COMPARE_FIELD_SEL
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    logic [31:0] ofs;
    assign ofs = LONG_FORM ? {{6{INSN[25]}}, INSN[25:2], 2'h0} : {{16{INSN[15]}}, INSN[15:2], 2'h0};
    rel_target_a: assert property ($past(INSN_VALID && !SRST && !INSN[1]) |->
        BRANCH_TARGET_ADDR == $past(CURRENT_INSN_ADDR + ofs)) else $error("relative target wrong");
    abs_target_a: assert property ($past(INSN_VALID && !SRST && INSN[1]) |->
        BRANCH_TARGET_ADDR == $past(ofs)) else $error("absolute target wrong");
    cond_sel_a: assert property (DEC_VALID |-> BRANCH_CONDITION_SELECTOR == $past(INSN[20:16]))
        else $error("condition selector wrong");
    options_a: assert property ($rose(DEC_VALID) |-> BRANCH_CONTROL_OPTIONS == $past(INSN[25:21]))
        else $error("branch options wrong");
    flag_src_a: assert property (DEC_VALID && !INSN_VALID |=> $stable(FLAG_LOGIC_SOURCE_ONE))
        else $error("flag source not held");
    flag_src_val_a: assert property (DEC_VALID |-> FLAG_LOGIC_SOURCE_ONE == $past(INSN[20:16]))
        else $error("flag source wrong");
    base_zero_a: assert property (DEC_VALID |-> BASE_OPERAND ==
        ($past(INSN[20:16]) == 5'h00 ? 32'h0000_0000 : $past(BASE_REG_DATA))) else $error("base operand wrong");
    base_select_a: assert property (DEC_VALID |-> BASE_OPERAND_SELECT == $past(INSN[20:16]))
        else $error("base selector wrong");
    flag_update_a: assert property (
        FLAG_UPDATE_EN == $past(INSN_VALID && !SRST && RECORD_CAPABLE && INSN[0])) else $error("flag update wrong");
    field_sel_a: assert property (DEC_VALID |-> COMPARE_FIELD_SEL == $past(INSN[25:23]))
        else $error("field selector wrong");
    abs_flag_a: assert property (DEC_VALID |-> ABSOLUTE_ADDRESS_FLAG == $past(INSN[1]))
        else $error("absolute flag wrong");
    cover property (DEC_VALID && FLAG_UPDATE_EN);
    cover property (DEC_VALID && ABSOLUTE_ADDRESS_FLAG);
    cover property (DEC_VALID && BRANCH_TARGET_ADDR[31]);
    cover property (DEC_VALID && BASE_OPERAND == 32'h0000_0000);
endmodule
`default_nettype wire
bind bfd_branch_field_decoder bfd_branch_field_decoder_chk chk (.*);

// >>> tb/bfd_branch_field_decoder_tb.sv
// Self-checking bench for the branch field decoder
`timescale 1ns/1ps
`default_nettype none
module bfd_branch_field_decoder_tb;
    logic        clk  = 1'b0;
    logic        rst  = 1'b1;
    logic        vld  = 1'b0;
    logic [31:0] insn = 32'h0000_0000;
    logic [31:0] addr = 32'h0000_0000;
    logic        lng  = 1'b0;
    logic        rec  = 1'b0;
    wire  logic [31:0] gpr;
    logic        dv, abs_f, fupd;
    logic [31:0] tgt, bop;
    logic [4:0]  bi, bo, fsrc, bsel;
    logic [2:0]  ffs, cfs;
    int          bad_count = 0;
    int          cmp_count = 0;
    int          cycles    = 0;
    bfd_gpr_model gm (.sel(insn[20:16]), .data(gpr));
    bfd_branch_field_decoder #(.RECORD_FIELD(3'h5)) dut (.REF_CLK(clk), .SRST(rst), .INSN_VALID(vld), .INSN(insn),
        .CURRENT_INSN_ADDR(addr), .LONG_FORM(lng), .RECORD_CAPABLE(rec), .BASE_REG_DATA(gpr), .DEC_VALID(dv),
        .BRANCH_TARGET_ADDR(tgt), .ABSOLUTE_ADDRESS_FLAG(abs_f), .BRANCH_CONDITION_SELECTOR(bi),
        .BRANCH_CONTROL_OPTIONS(bo), .FLAG_LOGIC_SOURCE_ONE(fsrc), .BASE_OPERAND_SELECT(bsel),
        .BASE_OPERAND(bop), .FLAG_UPDATE_EN(fupd), .FLAG_FIELD_SEL(ffs), .COMPARE_FIELD_SEL(cfs));
    always #25 clk = ~clk;
    task automatic complete_run;
        if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // One instruction per call; outputs are judged just after the taking edge
    task automatic issue(input logic [31:0] w, input logic [31:0] a, input logic l, input logic r);
        @(posedge clk);
        vld <= 1'b1;
        insn <= w;
        addr <= a;
        lng <= l;
        rec <= r;
        @(posedge clk);
        vld <= 1'b0;
        #1;
        check(32'(dv), 32'h0000_0001);
    endtask
    task automatic t_targets;
        issue(32'h0000_FFFC, 32'h0000_0100, 1'b0, 1'b0);
        check(tgt, 32'h0000_00FC);
        check(32'(abs_f), 32'h0000_0000);
        issue(32'h0000_0010, 32'hFFFF_FFF0, 1'b0, 1'b0);
        check(tgt, 32'h0000_0000);
        issue(32'h0000_FFFE, 32'h0000_0100, 1'b0, 1'b0);
        check(tgt, 32'hFFFF_FFFC);
        check(32'(abs_f), 32'h0000_0001);
        issue(32'h0200_0000, 32'h0000_1000, 1'b1, 1'b0);
        check(tgt, 32'hFE00_1000);
        issue(32'h01FF_FFFE, 32'h0000_1000, 1'b1, 1'b0);
        check(tgt, 32'h01FF_FFFC);
    endtask
    task automatic t_fields;
        for (int i = 0; i < 32; i++) begin
            issue({6'h00, 5'(31 - i), 5'(i), 16'h0000}, 32'h0000_0000, 1'b0, 1'b0);
            check(32'(bi), 32'(i));
            check(32'(bo), 32'(31 - i));
            check(32'(fsrc), 32'(i));
            check(32'(cfs), 32'((31 - i) >> 2));
            check(32'(bsel), 32'(i));
            check(bop, (i == 0) ? 32'h0000_0000 : (32'hA5A5_0000 | 32'(i)));
        end
    endtask
    task automatic t_record;
        for (int k = 0; k < 4; k++) begin
            issue({31'h0000_0000, k[0]}, 32'h0000_0000, 1'b0, k[1]);
            check(32'(fupd), 32'(k == 3));
        end
        check(32'(ffs), 32'h0000_0005);
        @(posedge clk);
        #1;
        check(32'(fupd), 32'h0000_0000);
    endtask
    // Mid-run reset with a record-form word pending; the word is taken right after release
    task automatic t_reset;
        @(posedge clk);
        rst  <= 1'b1;
        vld  <= 1'b1;
        insn <= 32'h0000_FFFF;
        addr <= 32'h0000_0100;
        lng  <= 1'b0;
        rec  <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        check(32'(dv), 32'h0000_0000);
        check(tgt, 32'h0000_0000);
        check(bop, 32'h0000_0000);
        check(32'(fupd), 32'h0000_0000);
        @(posedge clk);
        vld <= 1'b0;
        #1;
        check(32'(dv), 32'h0000_0001);
        check(tgt, 32'hFFFF_FFFC);
        check(32'(fupd), 32'h0000_0001);
        check(32'(ffs), 32'h0000_0005);
    endtask
    // Ceiling well above the roughly 100 cycles the scenarios need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_targets();
        t_fields();
        t_record();
        t_reset();
        complete_run();
    end
endmodule
`default_nettype wire
